// file: hw/epi_ctrl.sv
// epi_ctrl: external pin interrupt logic, top level
// assumes pins synchronous-safe via internal synchronisers, one clock,
// and a processor that pulses an acknowledge when a vector executes
`timescale 1ns/100ps

// What this block does
// - requests fire regardless of pin direction
// - upper group change raises group 1 request
// - lower group change raises group 0 request
// - per-pin mask gates group contribution
// - pin-change activity flagged as wake, from clocked samples
// - low level requests while pin stays low
// - edges recognised only with running clock
// - level and change conditions raise wake
// - dedicated request needs global and mask
// - sense fields at bits 3:2, 1:0
// - pins sampled first, edges from samples
// - sense codes: low, change, fall, rise
// - sense register bits 7:4 read zero
// - mask register bits 7:2 read zero
// - mask bit1 pin 1, bit0 pin 0
// - dedicated flags: set, ack, write-one clear
// - group flags: set, ack, write-one clear
// - group request needs enable and global
module epi_ctrl
  import epi_pkg::*;
#(
  parameter int PC_W = 2 * EPI_GROUP_W // pin-change inputs
) (
  input  wire logic            clk_in,                  // i/o clock, 100 MHz
  input  wire logic            rst_in,                  // sync reset, high
  // register port
  input  wire logic [2:0]      reg_addr_in,             // register offset
  input  wire logic [7:0]      reg_wdata_in,            // write data
  input  wire logic            reg_wr_in,               // write strobe
  input  wire logic            reg_rd_in,               // read strobe
  output logic      [7:0]      reg_rdata_out,           // read data, next cycle
  // pins
  input  wire logic [1:0]      dedicated_irq_pins_in,   // dedicated pins 1..0
  input  wire logic [PC_W-1:0] pin_change_inputs_in,    // pin-change pins
  // processor side
  input  wire logic            global_irq_enable_in,    // status word i-flag
  input  wire logic [1:0]      dedicated_ack_in,        // vector taken, pulse
  input  wire logic [1:0]      pc_group_ack_in,         // group vector taken
  output logic      [1:0]      dedicated_irq_req_out,   // dedicated requests
  output logic                 pin_change_group_0_request_out, // lower group
  output logic                 pin_change_group_1_request_out, // upper group
  output logic                 wake_out                 // wake cause, from clocked samples
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [3:0]             sense_r;       // ext_irq_sense_control used bits
  logic [1:0]             irq_mask_r;    // ext_irq_mask used bits
  logic [1:0]             ded_flag_r;    // dedicated flags
  logic [1:0]             pc_en_r;       // group enables
  logic [1:0]             pc_flag_r;     // group flags
  logic [EPI_GROUP_W-1:0] pc_msk_lo_r;   // pin_change_mask_lower
  logic [EPI_GROUP_W-1:0] pc_msk_hi_r;   // pin_change_mask_upper
  logic [7:0]             rdata_r;       // read data register

  // ------------------------------------------------------------
  // synchronised pins and detection
  // ------------------------------------------------------------
  logic [1:0]      ded_sync;   // dedicated pins after sync
  logic [1:0]      ded_prev_r; // previous dedicated sample
  logic            ded_seen_r; // first sample valid
  logic [PC_W-1:0] pc_sync;    // pin-change pins after sync
  logic [1:0]      ded_event;  // edge/change condition per pin
  logic [1:0]      ded_level;  // low-level condition per pin
  logic [1:0]      pc_hit;     // group change pulses
  logic            wr_sense;   // write decode
  logic            wr_mask;
  logic            wr_flag;
  logic            wr_pc_ctrl;
  logic            wr_pc_flag;
  logic            wr_msk_lo;
  logic            wr_msk_hi;

  // sense field of pin n, decoded as mode
  function automatic epi_sense_t sense_of(input logic [3:0] s, input int n);
    epi_sense_t m;
    m = epi_sense_t'(s[n*EPI_PAIR_BITS +: EPI_PAIR_BITS]);
    return m;
  endfunction : sense_of

  // request condition for one dedicated pin
  function automatic logic[1:0] detect(input epi_sense_t m, input logic cur, input logic prv);
    logic [1:0] r; // {level, event}
    r = 2'h0;
    case (m)
      EPI_SENSE_LOW:    r = {~cur, 1'b0};
      EPI_SENSE_CHANGE: r = {1'b0, cur ^ prv};
      EPI_SENSE_FALL:   r = {1'b0, prv & ~cur};
      EPI_SENSE_RISE:   r = {1'b0, ~prv & cur};
      default:          r = 2'h0;
    endcase
    return r;
  endfunction : detect

  // dedicated pins: direction-independent, pads read through the two-flop synchroniser
  epi_sync #(
    .W (2)
  ) u_ded_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (dedicated_irq_pins_in),
    .q_out  (ded_sync)
  );

  // pin-change pins share the same synchroniser style
  epi_sync #(
    .W (PC_W)
  ) u_pc_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (pin_change_inputs_in),
    .q_out  (pc_sync)
  );

  // ------------------------------------------------------------
  // dedicated pin previous sample
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ded_prev_r <= 2'h3;
      ded_seen_r <= 1'b0;
    end else begin
      ded_prev_r <= ded_sync;
      ded_seen_r <= 1'b1;
    end
  end

  // edges need the clock: detection comes from clocked samples
  always_comb begin
    logic [1:0] d;
    d = 2'h0;
    ded_event = 2'h0;
    ded_level = 2'h0;
    for (int n = 0; n < 2; n++) begin
      d = detect(sense_of(sense_r, n), ded_sync[n], ded_prev_r[n]);
      ded_level[n] = d[1];
      ded_event[n] = d[0] & ded_seen_r;
    end
  end

  // group detectors
  epi_pc_group #(
    .W (EPI_GROUP_W)
  ) u_pc_lo (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .pins_in (pc_sync[EPI_GROUP_W-1:0]),
    .mask_in (pc_msk_lo_r),
    .hit_out (pc_hit[0])
  );

  epi_pc_group #(
    .W (EPI_GROUP_W)
  ) u_pc_hi (
    .clk_in  (clk_in),
    .rst_in  (rst_in),
    .pins_in (pc_sync[PC_W-1:EPI_GROUP_W]),
    .mask_in (pc_msk_hi_r),
    .hit_out (pc_hit[1])
  );

  // ------------------------------------------------------------
  // write decode
  // ------------------------------------------------------------
  assign wr_sense   = reg_wr_in & (reg_addr_in == EPI_OFS_SENSE);
  assign wr_mask    = reg_wr_in & (reg_addr_in == EPI_OFS_MASK);
  assign wr_flag    = reg_wr_in & (reg_addr_in == EPI_OFS_FLAG);
  assign wr_pc_ctrl = reg_wr_in & (reg_addr_in == EPI_OFS_PC_CTRL);
  assign wr_pc_flag = reg_wr_in & (reg_addr_in == EPI_OFS_PC_FLAG);
  assign wr_msk_lo  = reg_wr_in & (reg_addr_in == EPI_OFS_PC_MSK_L);
  assign wr_msk_hi  = reg_wr_in & (reg_addr_in == EPI_OFS_PC_MSK_U);

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sense_r     <= EPI_SENSE_RST;
      irq_mask_r  <= EPI_PAIR_RST;
      pc_en_r     <= EPI_PAIR_RST;
      pc_msk_lo_r <= EPI_BYTE_RST;
      pc_msk_hi_r <= EPI_BYTE_RST;
    end else begin
      if (wr_sense) begin
        sense_r <= reg_wdata_in[EPI_SENSE_BITS-1:0]; // upper bits dropped
      end
      if (wr_mask) begin
        irq_mask_r <= reg_wdata_in[EPI_PAIR_BITS-1:0];
      end
      if (wr_pc_ctrl) begin
        pc_en_r <= reg_wdata_in[EPI_PAIR_BITS-1:0];
      end
      if (wr_msk_lo) begin
        pc_msk_lo_r <= reg_wdata_in;
      end
      if (wr_msk_hi) begin
        pc_msk_hi_r <= reg_wdata_in;
      end
    end
  end

  // ------------------------------------------------------------
  // dedicated flags: set wins over clear, level mode holds clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ded_flag_r <= EPI_PAIR_RST;
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (sense_of(sense_r, n) == EPI_SENSE_LOW) begin
          ded_flag_r[n] <= 1'b0;
        end else if (ded_event[n]) begin
          ded_flag_r[n] <= 1'b1;
        end else if (dedicated_ack_in[n] | (wr_flag & reg_wdata_in[n])) begin
          ded_flag_r[n] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // group flags: set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_flag_r <= EPI_PAIR_RST;
    end else begin
      for (int g = 0; g < 2; g++) begin
        if (pc_hit[g]) begin
          pc_flag_r[g] <= 1'b1;
        end else if (pc_group_ack_in[g] | (wr_pc_flag & reg_wdata_in[g])) begin
          pc_flag_r[g] <= 1'b0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // requests to processor
  // ------------------------------------------------------------
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      dedicated_irq_req_out[n] = global_irq_enable_in & irq_mask_r[n] &
                                 (ded_flag_r[n] | ded_level[n]);
    end
  end

  assign pin_change_group_0_request_out = global_irq_enable_in & pc_en_r[0] & pc_flag_r[0];
  assign pin_change_group_1_request_out = global_irq_enable_in & pc_en_r[1] & pc_flag_r[1];

  // wake cause: enabled level, change or pin-change activity
  always_comb begin
    logic w;
    w = 1'b0;
    for (int n = 0; n < 2; n++) begin
      if (irq_mask_r[n] & (ded_level[n] |
          ((sense_of(sense_r, n) == EPI_SENSE_CHANGE) & ded_event[n]))) begin
        w = 1'b1;
      end
    end
    wake_out = w | (|(pc_hit & pc_en_r));
  end

  // ------------------------------------------------------------
  // read port: data in the cycle after the strobe
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        EPI_OFS_SENSE:    rdata_r <= {4'h0, sense_r};
        EPI_OFS_MASK:     rdata_r <= {6'h00, irq_mask_r};
        EPI_OFS_FLAG:     rdata_r <= {6'h00, ded_flag_r};
        EPI_OFS_PC_CTRL:  rdata_r <= {6'h00, pc_en_r};
        EPI_OFS_PC_FLAG:  rdata_r <= {6'h00, pc_flag_r};
        EPI_OFS_PC_MSK_L: rdata_r <= pc_msk_lo_r;
        EPI_OFS_PC_MSK_U: rdata_r <= pc_msk_hi_r;
        EPI_OFS_PINS:     rdata_r <= {6'h00, ded_sync};
        default:          rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule : epi_ctrl

// file: hw/epi_pkg.sv
// epi_pkg: constants for the external pin interrupt block
// assumes an 8-bit register port with word-free byte offsets
package epi_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [2:0] EPI_OFS_SENSE    = 3'h0; // ext_irq_sense_control
  localparam logic [2:0] EPI_OFS_MASK     = 3'h1; // ext_irq_mask
  localparam logic [2:0] EPI_OFS_FLAG     = 3'h2; // dedicated pin flags
  localparam logic [2:0] EPI_OFS_PC_CTRL  = 3'h3; // pin-change group enables
  localparam logic [2:0] EPI_OFS_PC_FLAG  = 3'h4; // pin-change group flags
  localparam logic [2:0] EPI_OFS_PC_MSK_L = 3'h5; // pin_change_mask_lower
  localparam logic [2:0] EPI_OFS_PC_MSK_U = 3'h6; // pin_change_mask_upper
  localparam logic [2:0] EPI_OFS_PINS     = 3'h7; // live pin view

  // ------------------------------------------------------------
  // field positions and widths
  // ------------------------------------------------------------
  localparam int EPI_SENSE0_LSB = 0; // sense field pin 0 at bits 1:0
  localparam int EPI_SENSE1_LSB = 2; // sense field pin 1 at bits 3:2
  localparam int EPI_SENSE_BITS = 4; // used bits of sense register
  localparam int EPI_PAIR_BITS  = 2; // used bits of two-bit registers
  localparam int EPI_GROUP_W    = 8; // pins per pin-change group

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] EPI_SENSE_RST = 4'h0; // all low-level
  localparam logic [1:0] EPI_PAIR_RST  = 2'h0; // masks and flags clear
  localparam logic [7:0] EPI_BYTE_RST  = 8'h00; // group masks clear

  // ------------------------------------------------------------
  // sense modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EPI_SENSE_LOW    = 2'h0, // low level requests
    EPI_SENSE_CHANGE = 2'h1, // any logical change
    EPI_SENSE_FALL   = 2'h2, // falling edge
    EPI_SENSE_RISE   = 2'h3  // rising edge
  } epi_sense_t;

  // ------------------------------------------------------------
  // timing: pulse must outlast one clock period
  // ------------------------------------------------------------
  localparam int EPI_CLK_PERIOD_NS  = 10; // 100 MHz
  localparam int EPI_MIN_PULSE_NS   = 10; // one clock period
  localparam int EPI_MIN_PULSE_CYC  = (EPI_MIN_PULSE_NS + EPI_CLK_PERIOD_NS - 1) / EPI_CLK_PERIOD_NS;
  localparam int EPI_SYNC_STAGES    = 2;  // synchroniser depth

endpackage : epi_pkg

// file: hw/epi_sync.sv
// epi_sync: two-flop synchroniser for a vector of pins
// assumes a single clock; stage one feeds only stage two
`timescale 1ns/100ps
module epi_sync
  import epi_pkg::*;
#(
  parameter int W = 2 // number of pins
) (
  input  wire logic         clk_in,  // system clock
  input  wire logic         rst_in,  // sync reset, high
  input  wire logic [W-1:0] d_in,    // raw pins
  output logic      [W-1:0] q_out    // synchronised pins
);

  logic [W-1:0] meta_r; // first stage, read only by q_out

  // ------------------------------------------------------------
  // two stages
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_r <= '1; // idle high avoids false low-level requests
      q_out  <= '1;
    end else begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end

endmodule : epi_sync

// file: hw/epi_pc_group.sv
// epi_pc_group: change detection for one group of pin-change inputs
// assumes the pins arrive already synchronised
`timescale 1ns/100ps
module epi_pc_group
  import epi_pkg::*;
#(
  parameter int W = EPI_GROUP_W // pins in the group
) (
  input  wire logic         clk_in,   // system clock
  input  wire logic         rst_in,   // sync reset, high
  input  wire logic [W-1:0] pins_in,  // synchronised group pins
  input  wire logic [W-1:0] mask_in,  // per-pin enables
  output logic              hit_out   // one-cycle change pulse
);

  logic [W-1:0] prev_r; // previous sample
  logic         seen_r; // first sample taken after reset

  // ------------------------------------------------------------
  // compare with previous sample, gate by mask
  // ------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prev_r <= '0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= pins_in;
      seen_r <= 1'b1;
    end
  end

  // only masked pins count; no hit before first sample
  assign hit_out = seen_r & (|((pins_in ^ prev_r) & mask_in));

endmodule : epi_pc_group

// file: tb/epi_ctrl_monitor.sv
// epi_ctrl_monitor: port-level checks on the external pin interrupt block
// assumes bind onto epi_ctrl, one clock, sync active-high reset
`timescale 1ns/100ps
module epi_ctrl_monitor
  import epi_pkg::*;
#(
  parameter int PC_W = 16 // pin-change inputs
) (
  input wire logic            clk_in,                         // clock
  input wire logic            rst_in,                         // reset
  input wire logic [2:0]      reg_addr_in,                    // offset
  input wire logic [7:0]      reg_wdata_in,                   // write data
  input wire logic            reg_wr_in,                      // write strobe
  input wire logic            reg_rd_in,                      // read strobe
  input wire logic [7:0]      reg_rdata_out,                  // read data
  input wire logic [1:0]      dedicated_irq_pins_in,          // pins
  input wire logic [PC_W-1:0] pin_change_inputs_in,           // change pins
  input wire logic            global_irq_enable_in,           // global flag
  input wire logic [1:0]      dedicated_ack_in,               // vector acks
  input wire logic [1:0]      pc_group_ack_in,                // group acks
  input wire logic [1:0]      dedicated_irq_req_out,          // requests
  input wire logic            pin_change_group_0_request_out, // lower
  input wire logic            pin_change_group_1_request_out, // upper
  input wire logic            wake_out                        // wake
);
  // ----
  // shadow of written control, age since reset
  // ----
  logic [3:0] sns_r; // sense fields
  logic [1:0] msk_r; // dedicated enables
  logic [1:0] pce_r; // group enables
  logic [7:0] pcm_r; // lower group mask
  logic [2:0] age_r; // settles synchronisers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sns_r <= 4'h0;
      msk_r <= 2'h0;
      pce_r <= 2'h0;
      pcm_r <= 8'h00;
    end else if (reg_wr_in) begin
      if (reg_addr_in == EPI_OFS_SENSE) sns_r <= reg_wdata_in[3:0];
      if (reg_addr_in == EPI_OFS_MASK) msk_r <= reg_wdata_in[1:0];
      if (reg_addr_in == EPI_OFS_PC_CTRL) pce_r <= reg_wdata_in[1:0];
      if (reg_addr_in == EPI_OFS_PC_MSK_L) pcm_r <= reg_wdata_in;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) age_r <= 3'h0;
    else if (age_r != 3'h4) age_r <= age_r + 3'h1;
  end
  logic ok, q0, qg0;
  assign ok  = (age_r == 3'h4);
  assign q0  = !dedicated_ack_in[0] && !(reg_wr_in && reg_addr_in == EPI_OFS_FLAG);
  assign qg0 = !pc_group_ack_in[0] && !(reg_wr_in && reg_addr_in == EPI_OFS_PC_FLAG);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----
  // multi-step events
  // ----
  sequence s_rise0;
    ok && sns_r[1:0] == EPI_SENSE_RISE && $rose(dedicated_irq_pins_in[0]) ##1 dedicated_irq_pins_in[0];
  endsequence
  sequence s_pc0;
    ok && |((pin_change_inputs_in[7:0] ^ $past(pin_change_inputs_in[7:0])) & pcm_r)
      ##1 $stable(pin_change_inputs_in[7:0]);
  endsequence
  chk_sense_pad: assert property (reg_rd_in && reg_addr_in == EPI_OFS_SENSE |=> reg_rdata_out[7:4] == 4'h0)
    else $error("sense register upper bits not zero");
  chk_mask_pad: assert property (reg_rd_in && reg_addr_in == EPI_OFS_MASK |=> reg_rdata_out[7:2] == 6'h00)
    else $error("mask register upper bits not zero");
  chk_ded_gate: assert property (dedicated_irq_req_out != 2'h0 |->
    global_irq_enable_in && (dedicated_irq_req_out & ~msk_r) == 2'h0) else $error("ungated dedicated request");
  chk_grp_gate: assert property (pin_change_group_0_request_out || pin_change_group_1_request_out |->
    global_irq_enable_in && !(pin_change_group_0_request_out && !pce_r[0])
    && !(pin_change_group_1_request_out && !pce_r[1])) else $error("ungated group request");
  chk_low_req: assert property ((ok && sns_r[1:0] == EPI_SENSE_LOW && msk_r[0] && !dedicated_irq_pins_in[0])[*3]
    ##0 global_irq_enable_in |-> dedicated_irq_req_out[0]) else $error("low level not requesting");
  chk_low_noflag: assert property ((ok && sns_r[1:0] == EPI_SENSE_LOW && dedicated_irq_pins_in[0])[*3]
    |-> !dedicated_irq_req_out[0]) else $error("request in low mode with pin high");
  chk_rise_req: assert property (s_rise0 ##1 (q0 && global_irq_enable_in && msk_r[0]
    && sns_r[1:0] == EPI_SENSE_RISE)[*3] |-> dedicated_irq_req_out[0]) else $error("rising edge missed");
  chk_pc_req: assert property (s_pc0 ##1 (qg0 && pce_r[0] && global_irq_enable_in)[*3]
    |-> pin_change_group_0_request_out) else $error("lower group change missed");
endmodule : epi_ctrl_monitor

bind epi_ctrl epi_ctrl_monitor #(.PC_W(PC_W)) i_mon (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .dedicated_irq_pins_in(dedicated_irq_pins_in), .pin_change_inputs_in(pin_change_inputs_in),
  .global_irq_enable_in(global_irq_enable_in), .dedicated_ack_in(dedicated_ack_in),
  .pc_group_ack_in(pc_group_ack_in), .dedicated_irq_req_out(dedicated_irq_req_out),
  .pin_change_group_0_request_out(pin_change_group_0_request_out),
  .pin_change_group_1_request_out(pin_change_group_1_request_out), .wake_out(wake_out));

// file: tb/epi_pin_model.sv
// epi_pin_model: board-level sources on the interrupt pins
// assumes the bench calls its tasks; levels change after a rising edge
`timescale 1ns/100ps
module epi_pin_model (
  input  wire logic        clk_in,  // bench clock
  output logic      [1:0]  ded_out, // dedicated pin levels
  output logic      [15:0] pc_out   // pin-change levels
);
  // idle: dedicated pins pulled high, change pins low
  initial begin
    ded_out = 2'h3;
    pc_out  = 16'h0000;
  end
  // level held until told otherwise, past any start-up time
  task automatic set_ded(input int n, input logic v);
    @(posedge clk_in);
    ded_out[n] <= v;
  endtask : set_ded
  // one toggle, then held
  task automatic toggle_pc(input int n);
    @(posedge clk_in);
    pc_out[n] <= ~pc_out[n];
  endtask : toggle_pc
endmodule : epi_pin_model

// file: tb/external_pin_interrupt_logic_bench.sv
// bench: register and pin scenarios for epi_ctrl
// assumes epi_pkg offsets and the pin model beside the design
`timescale 1ns/100ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module external_pin_interrupt_logic_bench;
  import epi_pkg::*;
  // ----
  // stimulus and observation
  // ----
  logic        clk_in, rst_in, wr, rd, glb, g0, g1, wake, fall, rise;
  logic [2:0]  addr;  // offset
  logic [7:0]  wdata, rdata;
  logic [1:0]  ded, dack, pack, dreq;
  logic [15:0] pc;
  int          error_cnt, total_checks, cyc;
  epi_pin_model i_pins (.clk_in(clk_in), .ded_out(ded), .pc_out(pc));
  epi_ctrl #(.PC_W(16)) i_dut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .dedicated_irq_pins_in(ded),
    .pin_change_inputs_in(pc), .global_irq_enable_in(glb), .dedicated_ack_in(dack), .pc_group_ack_in(pack),
    .dedicated_irq_req_out(dreq), .pin_change_group_0_request_out(g0),
    .pin_change_group_1_request_out(g1), .wake_out(wake));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // ----
  // bus tasks
  // ----
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 `CHK("rdata", e, rdata)
  endtask : rd_chk
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk_in);
  endtask : wait_n
  task automatic results;
    if (error_cnt == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  // hang guard
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      results();
    end
  end
  // ----
  // scenarios
  // ----
  initial begin
    {addr, wdata, wr, rd, glb, dack, pack} = '0;
    rst_in = 1'b1;
    wait_n(12);
    rst_in <= 1'b0;
    wait_n(4);
    for (int a = 0; a < 7; a++) rd_chk(3'(a), 8'h00);
    wr_reg(EPI_OFS_PINS, 8'h00);
    rd_chk(EPI_OFS_PINS, 8'h03);
    wr_reg(EPI_OFS_SENSE, 8'hff);
    rd_chk(EPI_OFS_SENSE, 8'h0f);
    wr_reg(EPI_OFS_MASK, 8'hff);
    rd_chk(EPI_OFS_MASK, 8'h03);
    wr_reg(EPI_OFS_PC_MSK_L, 8'h01);
    wr_reg(EPI_OFS_PC_MSK_U, 8'h80);
    glb <= 1'b1;
    // every sense code on each pin: fall then rise
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 4; m++) begin
        fall = (m == 1 || m == 2);
        rise = (m == 1 || m == 3);
        wr_reg(EPI_OFS_SENSE, 8'(m << (2 * n)));
        wr_reg(EPI_OFS_FLAG, 8'h03);
        i_pins.set_ded(n, 1'b0);
        wait_n(5);
        `CHK("request", (m == 0 || fall), dreq[n])
        if (m == 0) `CHK("wake", 1'b1, wake)
        rd_chk(EPI_OFS_FLAG, {6'h00, fall && n == 1, fall && n == 0});
        wr_reg(EPI_OFS_FLAG, 8'h03);
        i_pins.set_ded(n, 1'b1);
        wait_n(5);
        `CHK("request", rise, dreq[n])
        rd_chk(EPI_OFS_FLAG, {6'h00, rise && n == 1, rise && n == 0});
      end
    end
    // short pulse in change mode, then gating and ack
    wr_reg(EPI_OFS_SENSE, 8'h01);
    wr_reg(EPI_OFS_FLAG, 8'h03);
    i_pins.set_ded(0, 1'b0);
    wait_n(1);
    i_pins.set_ded(0, 1'b1);
    wait_n(5);
    glb <= 1'b0;
    #1 `CHK("request", 2'h0, dreq)
    glb <= 1'b1;
    wr_reg(EPI_OFS_MASK, 8'h02);
    #1 `CHK("request", 2'h0, dreq)
    wr_reg(EPI_OFS_MASK, 8'h01);
    #1 `CHK("request", 2'h1, dreq)
    @(posedge clk_in);
    dack <= 2'h1;
    @(posedge clk_in);
    dack <= 2'h0;
    #1 `CHK("request", 2'h0, dreq)
    // pin-change groups
    wr_reg(EPI_OFS_PC_CTRL, 8'h03);
    i_pins.toggle_pc(1);
    wait_n(5);
    rd_chk(EPI_OFS_PC_FLAG, 8'h00);
    i_pins.toggle_pc(0);
    wait_n(5);
    `CHK("group 0", 1'b1, g0)
    i_pins.toggle_pc(15);
    wait_n(5);
    `CHK("group 1", 1'b1, g1)
    rd_chk(EPI_OFS_PC_FLAG, 8'h03);
    glb <= 1'b0;
    #1 `CHK("groups", 2'h0, {g1, g0})
    glb <= 1'b1;
    wr_reg(EPI_OFS_PC_FLAG, 8'h01);
    @(posedge clk_in);
    pack <= 2'h2;
    @(posedge clk_in);
    pack <= 2'h0;
    #1 `CHK("groups", 2'h0, {g1, g0})
    results();
  end
endmodule : external_pin_interrupt_logic_bench
